/* File: fcitc_pkg.sv */
package fcitc_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_REQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_MISC_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_REQ_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_MISC_REQ = 8'h14;
  localparam logic [7:0] ADDR_ERROR = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_QUEUE_DATA = 8'h24;
  localparam logic [7:0] ADDR_QUEUE_LEVEL = 8'h28;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h2C;
  localparam logic [7:0] ADDR_CONTROL = 8'h30;
  localparam logic [7:0] ADDR_MODE = 8'h44;
  localparam logic [7:0] ADDR_DEMOD = 8'h64;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'h84;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'hA8;
  localparam logic [7:0] ADDR_TIMER_DIV_LOW = 8'hAC;
  localparam logic [7:0] ADDR_TIMER_RELOAD = 8'hB0;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'hB8;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int REQ_TIMER = 0;
  localparam int REQ_ERROR = 1;
  localparam int REQ_NEARLY_EMPTY = 2;
  localparam int REQ_NEARLY_FULL = 3;
  localparam int REQ_IDLE = 4;
  localparam int REQ_RX = 5;
  localparam int REQ_TX = 6;
  localparam int REQ_SET_MODE = 7;
  localparam int MISC_CRC = 2;
  localparam int ERR_OVERRUN = 4;
  localparam int LEVEL_FLUSH = 7;
  localparam int CTRL_GO = 6;
  localparam int CTRL_HALT = 7;
  localparam int TMODE_AUTO = 7;
  localparam int TMODE_RESTART = 4;
  localparam int MODE_MSB_FIRST = 3;
  localparam int DEMOD_EVEN_DIV = 4;

  // ------------------------------------------------------------
  // Commands, CRC and timing
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FCITC_CMD_IDLE = 4'h0,
    FCITC_CMD_CALC_CRC = 4'h3
  } fcitc_cmd_t;

  localparam logic [15:0] CRC_PRESET_0 = 16'h0000;
  localparam logic [15:0] CRC_PRESET_1 = 16'h6363;
  localparam logic [15:0] CRC_PRESET_2 = 16'hA671;
  localparam logic [15:0] CRC_PRESET_3 = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_MSB = 16'h1021;
  localparam logic [15:0] CRC_POLY_LSB = 16'h8408;

  localparam int QUEUE_DEPTH = 64;
  localparam logic [6:0] QUEUE_FULL_LEVEL = 7'h40;

  // Timer base 13.56 MHz made from pclk 200 MHz by a phase accumulator
  localparam int PCLK_KHZ = 200000;
  localparam int TIMER_KHZ = 13560;
  localparam logic [17:0] ACC_MODULUS = 18'(PCLK_KHZ);
  localparam logic [17:0] ACC_STEP = 18'(TIMER_KHZ);
endpackage

/* File: fcitc_core.sv */
`timescale 1ns/10ps
`default_nettype none

module fcitc_core
  import fcitc_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the frame and command logic
  input wire logic tx_frame_end,
  input wire logic rx_frame_end,
  input wire logic protocol_event,
  input wire logic cmd_finish,
  input wire logic [3:0] link_error,
  // Queue port of the command logic
  input wire logic sm_push,
  input wire logic [7:0] sm_push_data,
  input wire logic sm_pop,
  output logic [7:0] sm_pop_data,
  // Interrupt pin
  output logic irq
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in,
                                           input logic [7:0] data,
                                           input logic msb_first);
    logic [15:0] c;
    c = crc_in;
    if (msb_first) begin
      c = c ^ {data, 8'h00};
      for (int i = 0; i < 8; i++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY_MSB) : {c[14:0], 1'b0};
      end
    end else begin
      c = c ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ({1'b0, c[15:1]} ^ CRC_POLY_LSB) : {1'b0, c[15:1]};
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] crc_preset(input logic [1:0] sel);
    case (sel)
      2'h0: return CRC_PRESET_0;
      2'h1: return CRC_PRESET_1;
      2'h2: return CRC_PRESET_2;
      default: return CRC_PRESET_3;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [3:0] command_register;
  logic [6:0] request_enable_register;
  logic [7:0] misc_enable_register;
  logic [6:0] request_flags_register;
  logic [7:0] misc_request_register;
  logic [3:0] link_error_flags;
  logic queue_overrun_error;
  logic [5:0] fill_threshold;
  logic [7:0] general_mode_register;
  logic [7:0] demod_config_register;
  logic [7:0] timer_mode_register;
  logic [7:0] timer_divider_low_register;
  logic [15:0] timer_reload_register;
  logic [15:0] timer_count_register;
  logic timer_active;
  logic timer_skip;
  logic [12:0] div_count;
  logic [17:0] tick_acc;
  logic [15:0] crc_value;
  logic checksum_ready;
  logic nearly_full_d;
  logic nearly_empty_d;
  logic [7:0] queue_mem [QUEUE_DEPTH];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] queue_fill_count;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire access = psel && penable;
  wire wr_fire = access && pready && pwrite;
  wire rd_fire = access && pready && !pwrite;
  wire wr_cmd = wr_fire && (paddr == ADDR_COMMAND);
  wire wr_flags = wr_fire && (paddr == ADDR_REQ_FLAGS);
  wire wr_misc = wr_fire && (paddr == ADDR_MISC_REQ);
  wire wr_error = wr_fire && (paddr == ADDR_ERROR);
  wire wr_level = wr_fire && (paddr == ADDR_QUEUE_LEVEL);
  wire wr_control = wr_fire && (paddr == ADDR_CONTROL);
  wire host_push = wr_fire && (paddr == ADDR_QUEUE_DATA);
  wire host_pop = rd_fire && (paddr == ADDR_QUEUE_DATA);
  wire queue_clear = wr_level && pwdata[LEVEL_FLUSH];

  // ------------------------------------------------------------
  // Queue
  // ------------------------------------------------------------
  wire queue_empty = (queue_fill_count == 7'h00);
  wire queue_full = (queue_fill_count == QUEUE_FULL_LEVEL);
  wire crc_busy = (command_register == FCITC_CMD_CALC_CRC);
  wire crc_pop = crc_busy && !queue_empty && !host_pop && !sm_pop;
  wire push_req = host_push || sm_push;
  wire [7:0] push_data = host_push ? pwdata[7:0] : sm_push_data;
  wire do_push = push_req && !queue_full && !queue_clear;
  wire do_pop = (host_pop || sm_pop || crc_pop) && !queue_empty && !queue_clear;
  wire [7:0] head_byte = queue_mem[rd_ptr];
  wire [6:0] next_fill = queue_fill_count + {6'h00, do_push} - {6'h00, do_pop};

  // Nearly full / nearly empty
  wire [6:0] free_count = QUEUE_FULL_LEVEL - queue_fill_count;
  wire nearly_full_status = (free_count <= {1'b0, fill_threshold});
  wire nearly_empty_status = (queue_fill_count <= {1'b0, fill_threshold});

  // ------------------------------------------------------------
  // Timer decode
  // ------------------------------------------------------------
  wire next_tick_wrap = ((tick_acc + ACC_STEP) >= ACC_MODULUS);
  wire [11:0] timer_divider_value = {timer_mode_register[3:0], timer_divider_low_register};
  wire even_div = demod_config_register[DEMOD_EVEN_DIV];
  wire [12:0] div_reload = {timer_divider_value, even_div};
  wire timer_go = wr_control && pwdata[CTRL_GO];
  wire timer_halt = wr_control && pwdata[CTRL_HALT];
  wire auto_go = timer_mode_register[TMODE_AUTO] && protocol_event;
  wire timer_start = (timer_go || auto_go) && !timer_halt;
  wire div_end = timer_active && next_tick_wrap && (div_count == 13'h0000);
  wire timer_expire = div_end && !timer_skip && (timer_count_register == 16'h0001);

  // ------------------------------------------------------------
  // Flag events
  // ------------------------------------------------------------
  wire [7:0] error_flags_register = {3'h0, queue_overrun_error, link_error_flags};
  wire crc_done_event = crc_busy && queue_empty && !checksum_ready;
  wire [6:0] hw_set;
  assign hw_set[REQ_TIMER] = timer_expire;
  assign hw_set[REQ_ERROR] = |error_flags_register;
  assign hw_set[REQ_NEARLY_EMPTY] = nearly_empty_status && !nearly_empty_d;
  assign hw_set[REQ_NEARLY_FULL] = nearly_full_status && !nearly_full_d;
  assign hw_set[REQ_IDLE] = cmd_finish && (command_register != FCITC_CMD_IDLE);
  assign hw_set[REQ_RX] = rx_frame_end;
  assign hw_set[REQ_TX] = tx_frame_end;
  wire [6:0] flag_mask = pwdata[6:0];
  wire [6:0] host_flags = !wr_flags ? request_flags_register :
    (pwdata[REQ_SET_MODE] ? (request_flags_register | flag_mask)
                          : (request_flags_register & ~flag_mask));
  wire [7:0] host_misc = !wr_misc ? misc_request_register :
    (pwdata[REQ_SET_MODE] ? (misc_request_register | {1'b0, pwdata[6:0]})
                          : (misc_request_register & ~{1'b0, pwdata[6:0]}));
  wire [6:0] next_flags = host_flags | hw_set;
  wire [7:0] next_misc = host_misc | {5'h00, crc_done_event, 2'h0};
  wire summary_request = |(request_flags_register & request_enable_register) ||
    |(misc_request_register & misc_enable_register);

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire [7:0] primary_status_register = {2'h0, checksum_ready, summary_request, timer_active,
    1'b0, nearly_full_status, nearly_empty_status};
  logic [31:0] read_mux;
  logic addr_ok;
  always_comb begin
    read_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      ADDR_COMMAND: read_mux = {28'h000_0000, command_register};
      ADDR_REQ_ENABLE: read_mux = {25'h000_0000, request_enable_register};
      ADDR_MISC_ENABLE: read_mux = {24'h00_0000, misc_enable_register};
      ADDR_REQ_FLAGS: read_mux = {25'h000_0000, request_flags_register};
      ADDR_MISC_REQ: read_mux = {24'h00_0000, misc_request_register};
      ADDR_ERROR: read_mux = {24'h00_0000, error_flags_register};
      ADDR_STATUS: read_mux = {24'h00_0000, primary_status_register};
      ADDR_QUEUE_DATA: read_mux = {24'h00_0000, queue_empty ? 8'h00 : head_byte};
      ADDR_QUEUE_LEVEL: read_mux = {25'h000_0000, queue_fill_count};
      ADDR_THRESHOLD: read_mux = {26'h000_0000, fill_threshold};
      ADDR_CONTROL: read_mux = 32'h0000_0000;
      ADDR_MODE: read_mux = {24'h00_0000, general_mode_register};
      ADDR_DEMOD: read_mux = {24'h00_0000, demod_config_register};
      ADDR_CRC_HIGH: read_mux = {24'h00_0000, crc_value[15:8]};
      ADDR_CRC_LOW: read_mux = {24'h00_0000, crc_value[7:0]};
      ADDR_TIMER_MODE: read_mux = {24'h00_0000, timer_mode_register};
      ADDR_TIMER_DIV_LOW: read_mux = {24'h00_0000, timer_divider_low_register};
      ADDR_TIMER_RELOAD: read_mux = {16'h0000, timer_reload_register};
      ADDR_TIMER_COUNT: read_mux = {16'h0000, timer_count_register};
      default: addr_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // APB answer: one wait state
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : read_mux;
      pslverr <= !addr_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Host configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_enable_register <= 7'h00;
      misc_enable_register <= 8'h00;
      fill_threshold <= 6'h08;
      general_mode_register <= 8'h3F;
      demod_config_register <= 8'h00;
      timer_mode_register <= 8'h00;
      timer_divider_low_register <= 8'h00;
      timer_reload_register <= 16'h0000;
    end else if (wr_fire) begin
      case (paddr)
        ADDR_REQ_ENABLE: request_enable_register <= pwdata[6:0];
        ADDR_MISC_ENABLE: misc_enable_register <= pwdata[7:0];
        ADDR_THRESHOLD: fill_threshold <= pwdata[5:0];
        ADDR_MODE: general_mode_register <= pwdata[7:0];
        ADDR_DEMOD: demod_config_register <= pwdata[7:0];
        ADDR_TIMER_MODE: timer_mode_register <= pwdata[7:0];
        ADDR_TIMER_DIV_LOW: timer_divider_low_register <= pwdata[7:0];
        ADDR_TIMER_RELOAD: timer_reload_register <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command, flags and errors
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_register <= FCITC_CMD_IDLE;
      request_flags_register <= 7'h00;
      misc_request_register <= 8'h00;
      link_error_flags <= 4'h0;
      queue_overrun_error <= 1'b0;
      nearly_full_d <= 1'b0;
      nearly_empty_d <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (cmd_finish) begin
        command_register <= FCITC_CMD_IDLE;
      end else if (wr_cmd) begin
        command_register <= pwdata[3:0];
      end
      request_flags_register <= next_flags;
      misc_request_register <= next_misc;
      link_error_flags <= (wr_error ? (link_error_flags & ~pwdata[3:0]) : link_error_flags)
        | link_error;
      if (push_req && queue_full && !queue_clear) begin
        queue_overrun_error <= 1'b1;
      end else if (queue_clear) begin
        queue_overrun_error <= 1'b0;
      end
      nearly_full_d <= nearly_full_status;
      nearly_empty_d <= nearly_empty_status;
      irq <= summary_request;
    end
  end

  // ------------------------------------------------------------
  // Queue storage and pointers
  // ------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (do_push) begin
      queue_mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      queue_fill_count <= 7'h00;
      sm_pop_data <= 8'h00;
    end else if (queue_clear) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      queue_fill_count <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 6'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 6'h01;
      end
      if (sm_pop && !host_pop && !queue_empty) begin
        sm_pop_data <= head_byte;
      end
      queue_fill_count <= next_fill;
    end
  end

  // ------------------------------------------------------------
  // CRC engine
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_value <= 16'h0000;
      checksum_ready <= 1'b0;
    end else if (wr_cmd && (pwdata[3:0] == FCITC_CMD_CALC_CRC)) begin
      crc_value <= crc_preset(general_mode_register[1:0]);
      checksum_ready <= 1'b0;
    end else if (crc_pop && !queue_clear) begin
      crc_value <= crc_byte(crc_value, head_byte,
        general_mode_register[MODE_MSB_FIRST]);
      checksum_ready <= 1'b0;
    end else if (crc_done_event) begin
      checksum_ready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Timer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_acc <= 18'h00000;
    end else if (next_tick_wrap) begin
      tick_acc <= tick_acc + ACC_STEP - ACC_MODULUS;
    end else begin
      tick_acc <= tick_acc + ACC_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_active <= 1'b0;
      timer_skip <= 1'b0;
      div_count <= 13'h0000;
      timer_count_register <= 16'h0000;
    end else if (timer_halt) begin
      timer_active <= 1'b0;
    end else if (timer_start) begin
      timer_active <= 1'b1;
      timer_skip <= 1'b1;
      div_count <= div_reload;
      timer_count_register <= timer_reload_register;
    end else if (timer_active && next_tick_wrap) begin
      if (div_count != 13'h0000) begin
        div_count <= div_count - 13'h0001;
      end else begin
        div_count <= div_reload;
        if (timer_skip) begin
          timer_skip <= 1'b0;
        end else if (timer_count_register != 16'h0000) begin
          timer_count_register <= timer_count_register - 16'h0001;
        end else if (timer_mode_register[TMODE_RESTART]) begin
          timer_count_register <= timer_reload_register;
        end else begin
          timer_active <= 1'b0;
        end
      end
    end
  end

endmodule // fcitc_core

`default_nettype wire

/* File: fcitc_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module fcitc_core_monitor
  import fcitc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and pin
  input wire logic tx_frame_end,
  input wire logic rx_frame_end,
  input wire logic irq
);
  logic [6:0] en_q;
  logic [7:0] misc_q;
  wire logic wr_done;
  wire logic rd_done;
  assign wr_done = pready && pwrite;
  assign rd_done = pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Copy of the enables, taken as the writes land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 7'h00;
      misc_q <= 8'h00;
    end else begin
      if (wr_done && paddr == ADDR_REQ_ENABLE) en_q <= pwdata[6:0];
      if (wr_done && paddr == ADDR_MISC_ENABLE) misc_q <= pwdata[7:0];
    end
  end
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("answer not after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  AST_UNMAPPED: assert property (pready && paddr == 8'h00 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_WR_ZERO: assert property (wr_done |-> prdata == 32'h0)
    else $error("read data on a write");
  AST_LEVEL: assert property (rd_done && paddr == ADDR_QUEUE_LEVEL |-> prdata <= 32'h40)
    else $error("fill count above depth");
  AST_CRC_BYTE: assert property (rd_done && paddr == ADDR_CRC_LOW |-> prdata[31:8] == 24'h0)
    else $error("checksum low byte too wide");
  AST_TX_IRQ: assert property (tx_frame_end && en_q[REQ_TX] |-> ##2 irq)
    else $error("no irq after transmit end");
  AST_RX_IRQ: assert property (rx_frame_end && en_q[REQ_RX] |=> ##1 irq)
    else $error("no irq after receive end");
  AST_IRQ_MASK: assert property ((en_q == 7'h00 && misc_q == 8'h00) [*2] |-> !irq)
    else $error("irq while all sources masked");
  cover property (pready && pslverr);
  cover property (tx_frame_end && en_q[REQ_TX]);
  cover property (wr_done && paddr == ADDR_QUEUE_DATA);
endmodule // fcitc_core_monitor
bind fcitc_core fcitc_core_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tx_frame_end, .rx_frame_end, .irq);
`default_nettype wire

/* File: fcitc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fcitc_host_model (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Released paddr and pwdata show the inverse, never a stale value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // fcitc_host_model
`default_nettype wire

/* File: fcitc_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fcitc_core_tb
  import fcitc_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sm_pop, sm_push;
  logic [3:0] ev, link_error;
  logic [7:0] paddr, sm_push_data, sm_pop_data;
  logic [31:0] pwdata, prdata;
  logic [15:0] x;
  logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  int te;
  fcitc_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_frame_end(ev[0]), .rx_frame_end(ev[1]), .protocol_event(ev[2]),
    .cmd_finish(ev[3]), .link_error, .sm_push, .sm_push_data, .sm_pop, .sm_pop_data, .irq);
  fcitc_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk((q & m) === (e & m), $sformatf("addr %h read %h", a, q));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] q;
    int n = 0;
    do begin
      host.xfer(1'b0, a, 32'h0, q);
      n++;
    end while ((q & m) === 32'h0 && n < 200);
    chk((q & m) !== 32'h0, "status bit never set");
  endtask
  task automatic pulse(input int b);
    @(posedge pclk) ev[b] <= 1'b1;
    @(posedge pclk) ev[b] <= 1'b0;
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c, input logic msb);
    logic [7:0] b [2] = '{8'h12, 8'h34};
    for (int j = 0; j < 2; j++) begin
      for (int n = 0; n < 8; n++) begin
        if (msb) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j][7 - n]) ? 16'h1021 : 16'h0000);
        else c = {1'b0, c[15:1]} ^ ((c[0] ^ b[j][n]) ? 16'h8408 : 16'h0000);
      end
    end
    return c;
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    chk(1'b0, "watchdog expired");
    print_verdict();
  end
  initial begin
    {presetn, sm_pop, sm_push, ev, link_error} = '0;
    sm_push_data = 8'hA5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_THRESHOLD, 32'h08, ALL);
    rd(ADDR_MODE, 32'h3F, ALL);
    rd(ADDR_STATUS, 32'h01, 32'h0B);
    rd(8'h00, 32'h00, ALL);
    $display("test reset done");
    for (int i = 0; i < 65; i++) begin
      wr(ADDR_QUEUE_DATA, 32'(i));
      if (i == 7 || i == 8) rd(ADDR_STATUS, {31'h0, i == 7}, 32'h01);
      if (i == 54 || i == 55) rd(ADDR_STATUS, {30'h0, i == 55, 1'b0}, 32'h02);
    end
    rd(ADDR_QUEUE_LEVEL, 32'h40, ALL);
    rd(ADDR_ERROR, 32'h10, 32'h10);
    wr(ADDR_ERROR, 32'hFF);
    rd(ADDR_ERROR, 32'h10, 32'h10);
    for (int i = 0; i < 3; i++) rd(ADDR_QUEUE_DATA, 32'(i), ALL);
    rd(ADDR_QUEUE_LEVEL, 32'h3D, ALL);
    wr(ADDR_QUEUE_LEVEL, 32'h80);
    rd(ADDR_QUEUE_LEVEL, 32'h00, ALL);
    rd(ADDR_ERROR, 32'h00, 32'h10);
    rd(ADDR_QUEUE_DATA, 32'h00, ALL);
    wr(ADDR_QUEUE_DATA, 32'h5A);
    @(posedge pclk) sm_pop <= 1'b1;
    @(posedge pclk) sm_pop <= 1'b0;
    @(posedge pclk);
    chk(sm_pop_data === 8'h5A, "command side pop data");
    @(posedge pclk) sm_push <= 1'b1;
    @(posedge pclk) sm_push <= 1'b0;
    rd(ADDR_QUEUE_DATA, 32'hA5, ALL);
    rd(ADDR_QUEUE_LEVEL, 32'h00, ALL);
    $display("test queue done");
    wr(ADDR_REQ_ENABLE, 32'h62);
    wr(ADDR_REQ_FLAGS, 32'h7F);
    pulse(0);
    rd(ADDR_REQ_FLAGS, 32'h40, 32'h7F);
    chk(irq === 1'b1, "irq missing");
    rd(ADDR_STATUS, 32'h10, 32'h10);
    wr(ADDR_REQ_FLAGS, 32'h40);
    pulse(1);
    rd(ADDR_REQ_FLAGS, 32'h20, 32'h60);
    @(posedge pclk) link_error <= 4'h2;
    @(posedge pclk) link_error <= 4'h0;
    rd(ADDR_REQ_FLAGS, 32'h02, 32'h02);
    wr(ADDR_ERROR, 32'h02);
    wr(ADDR_REQ_FLAGS, 32'h7F);
    rd(ADDR_REQ_FLAGS, 32'h00, 32'h7F);
    wr(ADDR_REQ_FLAGS, 32'h81);
    rd(ADDR_REQ_FLAGS, 32'h01, 32'h7F);
    wr(ADDR_REQ_ENABLE, 32'h00);
    $display("test events done");
    for (int k = 1; k < 6; k++) begin
      wr(ADDR_MODE, {28'h0, k < 5, 1'b0, 2'(k)});
      wr(ADDR_QUEUE_DATA, 32'h12);
      wr(ADDR_QUEUE_DATA, 32'h34);
      wr(ADDR_COMMAND, 32'h03);
      poll(ADDR_STATUS, 32'h20);
      x = crc(pre[k % 4], k < 5);
      rd(ADDR_CRC_HIGH, {24'h0, x[15:8]}, ALL);
      rd(ADDR_CRC_LOW, {24'h0, x[7:0]}, ALL);
      rd(ADDR_QUEUE_LEVEL, 32'h00, ALL);
      rd(ADDR_MISC_REQ, 32'h04, 32'h04);
      wr(ADDR_MISC_REQ, 32'h04);
      pulse(3);
      rd(ADDR_COMMAND, 32'h00, ALL);
      rd(ADDR_REQ_FLAGS, 32'h10, 32'h10);
      wr(ADDR_REQ_FLAGS, 32'h10);
    end
    $display("test checksum done");
    wr(ADDR_TIMER_DIV_LOW, 32'h01);
    wr(ADDR_TIMER_RELOAD, 32'h03);
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_DEMOD, {27'h0, v == 1, 4'h0});
      wr(ADDR_REQ_FLAGS, 32'h01);
      if (v == 1) wr(ADDR_TIMER_MODE, 32'h80);
      t0 = cyc;
      if (v == 0) wr(ADDR_CONTROL, 32'h40);
      else pulse(2);
      rd(ADDR_STATUS, 32'h08, 32'h08);
      poll(ADDR_REQ_FLAGS, 32'h01);
      te = (3 + v) * 4 * 20000 / 1356;
      chk(cyc - t0 >= te - 8 && cyc - t0 <= te + 28, "timer period");
      rd(ADDR_TIMER_COUNT, 32'h00, ALL);
      repeat (80) @(posedge pclk);
      rd(ADDR_STATUS, 32'h00, 32'h08);
    end
    $display("test timer done");
    print_verdict();
  end
endmodule // fcitc_core_tb
`default_nettype wire
